// [stc_timer.sv]
// 16-bit timer/counter with prescaler, buffered access and overflow flag
`timescale 1ns/1ps

module stc_timer (
  input  wire logic       SYS_CLK_IN,
  input  wire logic       RESET_IN,
  input  wire logic [2:0] ADDR_IN,
  input  wire logic [7:0] WDATA_IN,
  input  wire logic       WR_IN,
  input  wire logic       RD_IN,
  output logic      [7:0] RDATA_OUT,
  input  wire logic       EXT_CLK_IN,
  input  wire logic       CRYSTAL_CLK_IN,
  output logic            CRYSTAL_OSC_EN_OUT,
  input  wire logic       SYSCLK_FROM_CRYSTAL_IN,
  input  wire logic       COMPARE_TRIG_IN,
  input  wire logic [1:0] PORT_DIR_IN,
  input  wire logic [1:0] PIN_DATA_IN,
  output logic      [1:0] PIN_DIR_OUT,
  output logic      [1:0] PORT_READ_OUT,
  output logic            IRQ_OUT
);

  // ***************************************************************
  // Functions
  // ***************************************************************
  // Last prescaler count before a counter step for each divide code
  function automatic logic [2:0] presc_last(input logic [1:0] sel);
    logic [2:0] r;
    r = 3'h0;
    unique case (sel)
      2'h0: r = 3'h0;
      2'h1: r = 3'h1;
      2'h2: r = 3'h3;
      2'h3: r = 3'h7;
    endcase
    return r;
  endfunction : presc_last

  // ***************************************************************
  // State
  // ***************************************************************
  stc_pkg::stc_ctrl_s ctrl_reg;
  logic [15:0]        count_reg;
  logic [15:0]        count_next;
  logic [7:0]         hbuf_reg;
  logic [7:0]         hbuf_next;
  logic [2:0]         presc_reg;
  logic [2:0]         presc_next;
  logic [1:0]         phase_reg;
  logic               ovf_reg;
  logic               irq_en_reg;
  logic [7:0]         rdata_reg;
  logic [7:0]         rdata_next;
  logic               ext_s1_reg;
  logic               ext_s2_reg;
  logic               xtal_s1_reg;
  logic               xtal_s2_reg;
  logic               ext_prev_reg;
  logic               pend_reg;
  logic               pend_next;

  // ***************************************************************
  // Decode
  // ***************************************************************
  wire wr_ctrl  = WR_IN && (ADDR_IN == stc_pkg::ADDR_CONTROL);
  wire wr_low   = WR_IN && (ADDR_IN == stc_pkg::ADDR_COUNT_LOW);
  wire wr_high  = WR_IN && (ADDR_IN == stc_pkg::ADDR_COUNT_HIGH);
  wire wr_flags = WR_IN && (ADDR_IN == stc_pkg::ADDR_FLAGS);
  wire wr_irqen = WR_IN && (ADDR_IN == stc_pkg::ADDR_IRQ_ENABLE);
  wire rd_low   = RD_IN && (ADDR_IN == stc_pkg::ADDR_COUNT_LOW);
  wire wide     = ctrl_reg.wide_access_mode;

  // ***************************************************************
  // Count source selection
  // ***************************************************************
  // Crystal replaces the pin as external source when it is enabled
  // Each pin has its own synchroniser, so the mux only sees clean levels
  wire ext_sel    = ctrl_reg.crystal_osc_enable ? xtal_s2_reg
                                                : ext_s2_reg;
  wire instr_tick = (phase_reg == stc_pkg::INSTR_LAST);
  wire ext_rise   = ext_sel && !ext_prev_reg;
  wire sync_mode  = ctrl_reg.source_select && !ctrl_reg.sync_bypass;
  wire async_mode = ctrl_reg.source_select && ctrl_reg.sync_bypass;
  // Asynchronous mode counts on the edge itself, without waiting for
  // the instruction cycle, so it is quicker but the trigger is blocked
  wire ext_pulse  = ctrl_reg.sync_bypass ? ext_rise
                  : (instr_tick && (pend_reg || ext_rise));
  wire src_pulse  = ctrl_reg.source_select ? ext_pulse
                                           : instr_tick;
  wire step_ok    = ctrl_reg.count_run && src_pulse;
  wire presc_hit  = (presc_reg == presc_last(ctrl_reg.input_divide_sel));
  wire count_inc  = step_ok && presc_hit;
  wire wrap       = count_inc && (count_reg == stc_pkg::COUNT_TOP);
  wire trig_rst   = COMPARE_TRIG_IN && !async_mode;

  assign pend_next = sync_mode && !instr_tick && (pend_reg || ext_rise);

  // ***************************************************************
  // Prescaler and counter next values
  // ***************************************************************
  assign presc_next = wr_low    ? stc_pkg::PRESC_RESET
                    : !step_ok  ? presc_reg
                    : presc_hit ? stc_pkg::PRESC_RESET
                    : 3'(presc_reg + 3'h1);

  // Writes beat the trigger, which beats counting
  assign count_next =
      (wr_low && wide)  ? {hbuf_reg, WDATA_IN}
    : wr_low            ? {count_reg[15:8], WDATA_IN}
    : (wr_high && !wide) ? {WDATA_IN, count_reg[7:0]}
    : trig_rst          ? stc_pkg::COUNT_RESET
    : count_inc         ? 16'(count_reg + 16'h0001)
    : count_reg;

  assign hbuf_next = (wr_high && wide) ? WDATA_IN
                   : (rd_low && wide)  ? count_reg[15:8]
                   : hbuf_reg;

  // ***************************************************************
  // Read data, one cycle after the read strobe
  // ***************************************************************
  wire [7:0] ctrl_view = {ctrl_reg.wide_access_mode,
                          SYSCLK_FROM_CRYSTAL_IN,
                          ctrl_reg[5:0]};
  wire [7:0] high_view = wide ? hbuf_reg : count_reg[15:8];
  wire [7:0] rd_mux =
      (ADDR_IN == stc_pkg::ADDR_CONTROL)    ? ctrl_view
    : (ADDR_IN == stc_pkg::ADDR_COUNT_LOW)  ? count_reg[7:0]
    : (ADDR_IN == stc_pkg::ADDR_COUNT_HIGH) ? high_view
    : (ADDR_IN == stc_pkg::ADDR_FLAGS)      ? {7'h00, ovf_reg}
    : (ADDR_IN == stc_pkg::ADDR_IRQ_ENABLE) ? {7'h00, irq_en_reg}
    : stc_pkg::BYTE_ZERO;
  assign rdata_next = RD_IN ? rd_mux : stc_pkg::BYTE_ZERO;

  // ***************************************************************
  // Registers
  // ***************************************************************
  always_ff @(posedge SYS_CLK_IN or posedge RESET_IN) begin
    if (RESET_IN) begin
      ctrl_reg <= stc_pkg::CTRL_RESET;
    end else if (wr_ctrl) begin
      // Status bit is read-only and never stored
      ctrl_reg <= WDATA_IN & 8'hBF;
    end
  end

  always_ff @(posedge SYS_CLK_IN or posedge RESET_IN) begin
    if (RESET_IN) begin
      count_reg <= stc_pkg::COUNT_RESET;
      hbuf_reg  <= stc_pkg::BYTE_ZERO;
      presc_reg <= stc_pkg::PRESC_RESET;
      rdata_reg <= stc_pkg::BYTE_ZERO;
    end else begin
      count_reg <= count_next;
      hbuf_reg  <= hbuf_next;
      presc_reg <= presc_next;
      rdata_reg <= rdata_next;
    end
  end

  // Set beats a same-cycle clear so no wrap is lost
  always_ff @(posedge SYS_CLK_IN or posedge RESET_IN) begin
    if (RESET_IN) begin
      ovf_reg    <= 1'b0;
      irq_en_reg <= 1'b0;
    end else begin
      ovf_reg    <= wrap || (wr_flags ? WDATA_IN[stc_pkg::OVF_BIT]
                                      : ovf_reg);
      irq_en_reg <= wr_irqen ? WDATA_IN[stc_pkg::IRQ_EN_BIT] : irq_en_reg;
    end
  end

  // Synchronisers: only the second flop of each chain reads the first
  always_ff @(posedge SYS_CLK_IN or posedge RESET_IN) begin
    if (RESET_IN) begin
      ext_s1_reg   <= 1'b0;
      ext_s2_reg   <= 1'b0;
      xtal_s1_reg  <= 1'b0;
      xtal_s2_reg  <= 1'b0;
      ext_prev_reg <= 1'b0;
      pend_reg     <= 1'b0;
      phase_reg    <= stc_pkg::PHASE_RESET;
    end else begin
      ext_s1_reg   <= EXT_CLK_IN;
      ext_s2_reg   <= ext_s1_reg;
      xtal_s1_reg  <= CRYSTAL_CLK_IN;
      xtal_s2_reg  <= xtal_s1_reg;
      ext_prev_reg <= ext_sel;
      pend_reg     <= pend_next;
      phase_reg    <= 2'(phase_reg + 2'h1);
    end
  end

  // ***************************************************************
  // Outputs
  // ***************************************************************
  assign RDATA_OUT = rdata_reg;
  // No power-mode input gates this: the crystal runs through sleep
  assign CRYSTAL_OSC_EN_OUT = ctrl_reg.crystal_osc_enable;
  assign PIN_DIR_OUT   = ctrl_reg.count_run ? stc_pkg::PINS_INPUT
                                            : PORT_DIR_IN;
  assign PORT_READ_OUT = ctrl_reg.count_run ? stc_pkg::PINS_ZERO
                                            : PIN_DATA_IN;
  assign IRQ_OUT = ovf_reg && irq_en_reg;

  // ***************************************************************
  // Assertions
  // ***************************************************************
  default clocking cb @(posedge SYS_CLK_IN); endclocking
  default disable iff (RESET_IN);

  sequence quiet_s;
    !WR_IN && !COMPARE_TRIG_IN;
  endsequence

  stop_hold_a: assert property (
    ((!ctrl_reg.count_run) and quiet_s) |=> $stable(count_reg))
    else $error("counter moved while stopped");

  internal_rate_a: assert property (
    (count_inc && !ctrl_reg.source_select) |-> instr_tick)
    else $error("internal count off instruction cycle");

  presc_step_a: assert property (
    count_inc |=> presc_reg == stc_pkg::PRESC_RESET)
    else $error("prescaler not restarted after a counter step");

  low_write_presc_a: assert property (
    wr_low |=> presc_reg == stc_pkg::PRESC_RESET)
    else $error("prescaler kept after low write");

  wide_read_a: assert property (
    (rd_low && wide && !wr_high) |=> hbuf_reg == $past(count_reg[15:8]))
    else $error("high buffer missed low byte read");

  wide_write_a: assert property (
    (wr_low && wide) |=> count_reg == {$past(hbuf_reg), $past(WDATA_IN)})
    else $error("wide write not applied as one");

  wrap_flag_a: assert property (
    wrap |=> ovf_reg && count_reg == stc_pkg::COUNT_RESET)
    else $error("wrap did not set overflow flag");

  irq_gate_a: assert property (
    IRQ_OUT |-> ovf_reg && irq_en_reg)
    else $error("interrupt without flag and enable");

  trig_reset_a: assert property (
    (trig_rst && !wr_low && !(wr_high && !wide))
      |=> count_reg == stc_pkg::COUNT_RESET)
    else $error("trigger did not reset counter");

  pin_force_a: assert property (
    ctrl_reg.count_run |-> PIN_DIR_OUT == stc_pkg::PINS_INPUT
                           && PORT_READ_OUT == stc_pkg::PINS_ZERO)
    else $error("clock pins not forced while running");

  sync_delay_a: assert property (
    (sync_mode && ctrl_reg.count_run && ext_rise && !instr_tick)
      |-> !count_inc ##[1:3] src_pulse)
    else $error("synchronous edge not counted in time");

  narrow_write_a: assert property (
    (wr_high && !wide) |=> count_reg[15:8] == $past(WDATA_IN))
    else $error("narrow high write not applied");

  buf_write_a: assert property (
    (wr_high && wide && !count_inc && !trig_rst)
      |=> hbuf_reg == $past(WDATA_IN) && $stable(count_reg))
    else $error("wide high write reached the counter");

  high_presc_a: assert property (
    (wr_high && !step_ok) |=> $stable(presc_reg))
    else $error("high byte write changed prescaler");

  write_wins_a: assert property (
    (trig_rst && wr_low && !wide) |=> count_reg[7:0] == $past(WDATA_IN))
    else $error("trigger beat a counter write");

  async_trig_a: assert property (
    (COMPARE_TRIG_IN && async_mode && !wr_low && !wr_high && !count_inc)
      |=> $stable(count_reg))
    else $error("trigger reset counter in asynchronous mode");

  irq_follow_a: assert property (
    (ovf_reg && irq_en_reg) |-> IRQ_OUT)
    else $error("interrupt missing with flag and enable");

  ovf_sticky_a: assert property (
    (ovf_reg && !wr_flags) |=> ovf_reg)
    else $error("overflow flag dropped without a write");

  status_read_a: assert property (
    (RD_IN && ADDR_IN == stc_pkg::ADDR_CONTROL)
      |=> RDATA_OUT[6] == $past(SYSCLK_FROM_CRYSTAL_IN))
    else $error("clock status bit not reported");

  // Read data stands for one cycle only, so software cannot see stale data
  read_idle_a: assert property (
    !RD_IN |=> RDATA_OUT == stc_pkg::BYTE_ZERO)
    else $error("read data without a read strobe");

  // Buffered write: high byte into the buffer, then low byte loads both
  sequence hi_fill_s;
    wr_high && wide;
  endsequence

  sequence lo_load_s;
    wr_low && wide;
  endsequence

  wide_pair_a: assert property (
    (hi_fill_s ##1 (!WR_IN && !RD_IN) ##1 lo_load_s)
      |=> count_reg == {$past(WDATA_IN, 3), $past(WDATA_IN)})
    else $error("buffered high byte not loaded by low write");

  // Buffered read: low byte snapshot, then high read returns the snapshot
  sequence lo_snap_s;
    rd_low && wide;
  endsequence

  sequence hi_read_s;
    RD_IN && wide && ADDR_IN == stc_pkg::ADDR_COUNT_HIGH;
  endsequence

  wide_snap_a: assert property (
    (lo_snap_s ##1 (!WR_IN && !RD_IN) ##1 hi_read_s)
      |=> RDATA_OUT == $past(count_reg[15:8], 3))
    else $error("high read did not return low read snapshot");

endmodule : stc_timer

// [stc_pkg.sv]
// Package for the 16-bit timer/counter: register map, fields, reset values
package stc_pkg;

  // ***************************************************************
  // Register map (byte-wide registers on the plain port)
  // ***************************************************************
  localparam logic [2:0] ADDR_CONTROL    = 3'h0;
  localparam logic [2:0] ADDR_COUNT_LOW  = 3'h1;
  localparam logic [2:0] ADDR_COUNT_HIGH = 3'h2;
  localparam logic [2:0] ADDR_FLAGS      = 3'h3;
  localparam logic [2:0] ADDR_IRQ_ENABLE = 3'h4;

  // ***************************************************************
  // Field layout and reset values
  // ***************************************************************
  typedef struct packed {
    logic       wide_access_mode;
    logic       sysclk_from_crystal;
    logic [1:0] input_divide_sel;
    logic       crystal_osc_enable;
    logic       sync_bypass;
    logic       source_select;
    logic       count_run;
  } stc_ctrl_s;

  localparam stc_ctrl_s CTRL_RESET     = 8'h00;
  localparam logic [7:0] BYTE_ZERO     = 8'h00;
  localparam logic [15:0] COUNT_RESET  = 16'h0000;
  localparam logic [15:0] COUNT_TOP    = 16'hFFFF;
  localparam int          OVF_BIT      = 0;
  localparam int          IRQ_EN_BIT   = 0;

  // ***************************************************************
  // Timing: the instruction cycle is four oscillator clocks
  // ***************************************************************
  localparam int         SYS_CLK_HZ   = 40000000;
  localparam int         INSTR_DIV    = 4;
  localparam logic [1:0] INSTR_LAST   = 2'(INSTR_DIV - 1);
  localparam logic [1:0] PHASE_RESET  = 2'h0;
  localparam logic [2:0] PRESC_RESET  = 3'h0;
  localparam logic [1:0] PINS_INPUT   = 2'h3;
  localparam logic [1:0] PINS_ZERO    = 2'h0;

endpackage : stc_pkg

// [stc_ext_clock_model.sv]
// Model of the external count pin and the low-power crystal
`timescale 1ns/1ps
module stc_ext_clock_model (
  input  wire logic clk_in,
  input  wire logic osc_en_in,
  output logic      ext_clk_out,
  output logic      xtal_clk_out
);
  initial begin
    ext_clk_out = 1'b0;
    xtal_clk_out = 1'b0;
  end
  // Eight clocks high and low, slow against the synchroniser path
  task automatic ext_pulses(input int n);
    repeat (n) begin
      repeat (8) @(posedge clk_in);
      ext_clk_out <= 1'b1;
      repeat (8) @(posedge clk_in);
      ext_clk_out <= 1'b0;
    end
  endtask : ext_pulses
  // Idles low while shut off; power mode never stops it
  task automatic xtal_pulses(input int n);
    repeat (n) begin
      repeat (8) @(posedge clk_in);
      xtal_clk_out <= osc_en_in;
      repeat (8) @(posedge clk_in);
      xtal_clk_out <= 1'b0;
    end
  endtask : xtal_pulses
endmodule : stc_ext_clock_model

// [tb_stc_timer.sv]
// Self-checking bench for the 16-bit timer/counter
`timescale 1ns/1ps
module tb_stc_timer;
  localparam logic [2:0] CT = stc_pkg::ADDR_CONTROL;
  localparam logic [2:0] LO = stc_pkg::ADDR_COUNT_LOW;
  localparam logic [2:0] HI = stc_pkg::ADDR_COUNT_HIGH;
  localparam logic [2:0] FL = stc_pkg::ADDR_FLAGS;
  localparam logic [2:0] IE = stc_pkg::ADDR_IRQ_ENABLE;
  logic       clk = 1'b0, rst = 1'b1, wr_s = 1'b0, rd_s = 1'b0;
  logic       trig = 1'b0, sys_x = 1'b0, ext, xtal, osc_en, irq;
  logic [2:0] addr = 3'h0;
  logic [7:0] wdata = 8'h00, rdata, v, w;
  logic [1:0] pdir = 2'h0, pdat = 2'h2, dir_o, prd_o;
  int         fail_count = 0, n_checks = 0, cyc = 0, ex;

  stc_timer i_stc_timer (.SYS_CLK_IN(clk), .RESET_IN(rst), .ADDR_IN(addr),
    .WDATA_IN(wdata), .WR_IN(wr_s), .RD_IN(rd_s), .RDATA_OUT(rdata),
    .EXT_CLK_IN(ext), .CRYSTAL_CLK_IN(xtal), .CRYSTAL_OSC_EN_OUT(osc_en),
    .SYSCLK_FROM_CRYSTAL_IN(sys_x), .COMPARE_TRIG_IN(trig),
    .PORT_DIR_IN(pdir), .PIN_DATA_IN(pdat), .PIN_DIR_OUT(dir_o),
    .PORT_READ_OUT(prd_o), .IRQ_OUT(irq));
  stc_ext_clock_model i_stc_ext_clock_model (.clk_in(clk),
    .osc_en_in(osc_en), .ext_clk_out(ext), .xtal_clk_out(xtal));

  always #12.5 clk = ~clk;
  // Whole run needs about 1900 cycles
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 8000) begin
      fail_count++;
      give_verdict();
    end
  end

  // ***************************************************************
  // Bus tasks and compare
  // ***************************************************************
  task automatic wr(input logic [2:0] a, input logic [7:0] d,
                    input logic t = 1'b0);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr_s <= 1'b1;
    trig <= t;
    @(posedge clk);
    wr_s <= 1'b0;
    trig <= 1'b0;
  endtask : wr
  task automatic rd(input logic [2:0] a, output logic [7:0] d);
    @(posedge clk);
    addr <= a;
    rd_s <= 1'b1;
    @(posedge clk);
    rd_s <= 1'b0;
    #1 d = rdata;
  endtask : rd
  task automatic chk(input string nm, input logic [15:0] s, e);
    n_checks++;
    if (s !== e) begin
      fail_count++;
      $display("[ERR] %s expected %h seen %h", nm, e, s);
    end
  endtask : chk
  task automatic chk_rd(input string nm, input logic [2:0] a,
                        input logic [7:0] e);
    rd(a, v);
    chk(nm, 16'(v), 16'(e));
  endtask : chk_rd
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : give_verdict

  // ***************************************************************
  // Tests
  // ***************************************************************
  initial begin
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    #1 chk("dir_rst", 16'(dir_o), 16'(pdir));
    chk("prd_rst", 16'(prd_o), 16'(pdat));
    chk("osc_rst", 16'(osc_en), 16'h0);
    chk_rd("ctrl_rst", CT, 8'h00);
    wr(3'h5, 8'hFF);
    chk_rd("unmapped", 3'h5, 8'h00);
    wr(CT, 8'h40);
    chk_rd("ctrl_ro", CT, 8'h00);
    @(posedge clk) sys_x <= 1'b1;
    chk_rd("ctrl_stat", CT, 8'h40);
    @(posedge clk) sys_x <= 1'b0;
    wr(LO, 8'h00);
    repeat (40) @(posedge clk);
    chk_rd("stopped", LO, 8'h00);
    // Stopped: pins follow the port; values differ from the forced ones
    @(posedge clk) pdir <= 2'h1;
    pdat <= 2'h3;
    #1 chk("dir_stop", 16'(dir_o), 16'h1);
    chk("prd_stop", 16'(prd_o), 16'h3);
    // Bypass bit set on purpose: it must not matter for internal source
    for (int d = 0; d < 4; d++) begin
      wr(LO, 8'h00);
      wr(CT, 8'(8'h05 | (d << 4)));
      #1 chk("dir_run", 16'(dir_o), 16'h3);
      chk("prd_run", 16'(prd_o), 16'h0);
      repeat (320) @(posedge clk);
      wr(CT, 8'h00);
      rd(LO, w);
      ex = 320 / (4 << d);
      chk("rate", 16'(w >= ex - 2 && w <= ex + 2), 16'h1);
      repeat (20) @(posedge clk);
      chk_rd("hold", LO, w);
    end
    wr(LO, 8'h00);
    wr(CT, 8'h03);
    i_stc_ext_clock_model.ext_pulses(5);
    chk_rd("ext_sync", LO, 8'h05);
    wr(LO, 8'h00);
    wr(CT, 8'h07);
    i_stc_ext_clock_model.ext_pulses(5);
    chk_rd("ext_async", LO, 8'h05);
    wr(3'h5, 8'h00, 1'b1);
    chk_rd("trig_async", LO, 8'h05);
    wr(CT, 8'h17);
    i_stc_ext_clock_model.ext_pulses(1);
    wr(LO, 8'h00);
    i_stc_ext_clock_model.ext_pulses(1);
    chk_rd("presc_clr", LO, 8'h00);
    wr(HI, 8'h00);
    i_stc_ext_clock_model.ext_pulses(1);
    chk_rd("presc_keep", LO, 8'h01);
    wr(LO, 8'h00);
    wr(CT, 8'h0B);
    #1 chk("osc_on", 16'(osc_en), 16'h1);
    // Start-up delay before trusting the crystal
    repeat (40) @(posedge clk);
    fork
      i_stc_ext_clock_model.xtal_pulses(4);
      i_stc_ext_clock_model.ext_pulses(3);
    join
    chk_rd("xtal", LO, 8'h04);
    wr(CT, 8'h00);
    #1 chk("osc_off", 16'(osc_en), 16'h0);
    wr(LO, 8'h50);
    wr(3'h5, 8'h00, 1'b1);
    chk_rd("trig_clr", LO, 8'h00);
    wr(LO, 8'h77, 1'b1);
    chk_rd("trig_lose", LO, 8'h77);
    wr(CT, 8'h80);
    wr(HI, 8'h12);
    wr(LO, 8'h34);
    wr(CT, 8'h00);
    chk_rd("wide_load", HI, 8'h12);
    wr(HI, 8'h56);
    chk_rd("narrow_hi", HI, 8'h56);
    chk_rd("narrow_lo", LO, 8'h34);
    wr(CT, 8'h80);
    wr(HI, 8'hAB);
    wr(CT, 8'h00);
    chk_rd("buf_only", HI, 8'h56);
    wr(CT, 8'h80);
    chk_rd("wide_lo", LO, 8'h34);
    chk_rd("wide_hi", HI, 8'h56);
    wr(CT, 8'h00);
    wr(HI, 8'hFF);
    wr(LO, 8'hFF);
    wr(CT, 8'h01);
    repeat (12) @(posedge clk);
    wr(CT, 8'h00);
    chk_rd("wrap_hi", HI, 8'h00);
    chk_rd("ovf", FL, 8'h01);
    chk("irq_mask", 16'(irq), 16'h0);
    wr(IE, 8'h01);
    #1 chk("irq_on", 16'(irq), 16'h1);
    wr(FL, 8'h00);
    #1 chk("irq_off", 16'(irq), 16'h0);
    chk_rd("ovf_clr", FL, 8'h00);
    give_verdict();
  end
endmodule : tb_stc_timer
